// *** inc/daq_pkg.sv ***
// shared constants and carrier types for the acquisition card decode
package daq_pkg;
    localparam int ADDR_W = 10;
    localparam int OFF_W = 4;
    // base compare covers address bits 9 down to 4
    localparam int BASE_HI = 9;
    localparam int BASE_LO = 4;
    localparam logic [5:0] FACTORY_SWITCH = 6'h1d;
    localparam logic [9:0] FACTORY_BASE = 10'h220;
    localparam logic [3:0] OFF_TIMER0 = 4'h0;
    localparam logic [3:0] OFF_TIMER_CTRL = 4'h3;
    localparam logic [3:0] OFF_ADC_LOW = 4'h4;
    localparam logic [3:0] OFF_ADC_HIGH = 4'h5;
    localparam logic [3:0] OFF_DIN_LOW = 4'h6;
    localparam logic [3:0] OFF_DIN_HIGH = 4'h7;
    localparam logic [3:0] OFF_DAC0_LOW = 4'h4;
    localparam logic [3:0] OFF_DAC0_HIGH = 4'h5;
    localparam logic [3:0] OFF_DAC1_LOW = 4'h6;
    localparam logic [3:0] OFF_DAC1_HIGH = 4'h7;
    localparam logic [3:0] OFF_IRQ_CLEAR = 4'h8;
    localparam logic [3:0] OFF_GAIN = 4'h9;
    localparam logic [3:0] OFF_CHANNEL = 4'ha;
    localparam logic [3:0] OFF_MODE = 4'hb;
    localparam logic [3:0] OFF_SOFT_START = 4'hc;
    localparam logic [3:0] OFF_DOUT_LOW = 4'hd;
    localparam logic [3:0] OFF_DOUT_HIGH = 4'he;
    localparam logic [2:0] MODE_OFF = 3'h0;
    localparam logic [2:0] MODE_SOFT_POLL = 3'h1;
    localparam logic [2:0] MODE_PACER_DMA = 3'h2;
    localparam logic [2:0] MODE_PACER_IRQ = 3'h6;
    localparam int PENDING_BIT = 4;
    localparam int CONV_TIME_NS = 8000;
    localparam int CLK_PERIOD_NS = 25;
    localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int FIFO_DEPTH = 16;
    localparam int SAMPLE_W = 12;

    typedef enum logic [1:0] {
        CONV_IDLE = 2'h0,
        CONV_BUSY = 2'h1,
        CONV_STORE = 2'h3
    } conv_state_type;

    // access towards the three-counter timer part
    typedef struct packed {
        logic [1:0] select;
        logic read;
        logic write;
        logic [7:0] data;
    } timer_access_type;

    // clocks and gate towards the timer part
    typedef struct packed {
        logic clock0;
        logic clock2;
        logic gate12;
    } timer_wiring_type;
endpackage

// *** hw/daq_board_isa_register_decode.sv ***
// io port decode, converter sequencing and data path of the acquisition card
// Function
// - answer exactly 16 consecutive io ports from base, ignore all others
// - address bits 9..4 compared with switch; on means zero, off means one
// - factory switch setting decodes the window at 0x220
// - offsets 0-2 pass to counters; offset 3 writes control only
// - offset 4 reads result low byte, offset 5 upper four bits
// - high byte: result bits 11..8, pending in bit 4, bits 7..5 zero
// - pending reads one until result ready, cleared when conversion completes
// - pending lasts about the 8 us conversion time after each trigger
// - sixteen digital inputs read at offsets 6 and 7
// - sixteen digital outputs written at offsets d and e
// - offsets 4,5 load first converter output; 6,7 the second
// - writes 8..c: irq clear, gain, channel, mode, soft trigger
// - counters 1 and 2 cascade into the conversion pacer
// - counter 0 clock selectable between 2 MHz and external input
// - trigger from external input, or internally by software or pacer
// - event trigger lets counter 0 output gate the pacer counters
// - sixteen single-ended or eight differential inputs by board setting
// - dma requests on channel 1 or 3 when enabled; terminal count sets status, driven on irq only in mode 0x06
// - interrupt on one jumper-chosen level, only when enabled by mode
// - output converters double buffered; high byte write updates, low first
// - status set per conversion in irq mode; write at 8 clears it
// - channel bits 3..0 single-ended; differential uses 2..0 only
// - mode 0x01 soft poll, 0x06 pacer irq, 0x02 pacer dma
`timescale 1ns/100ps

module sample_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int PTR_W = $clog2(DEPTH);
    logic [WIDTH-1:0] store [DEPTH];
    logic [PTR_W-1:0] wrPtr_reg;
    logic [PTR_W-1:0] rdPtr_reg;
    logic [PTR_W:0] count_reg;
    wire push = inValid && inReady;
    wire pop = outValid && outReady;

    assign inReady = (count_reg != (PTR_W+1)'(DEPTH));
    assign outValid = (count_reg != '0);
    assign outData = store[rdPtr_reg];

    always_ff @(posedge clk) begin
        if (push) begin
            store[wrPtr_reg] <= inData;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wrPtr_reg <= wrPtr_reg + 1'b1;
            end
            if (pop) begin
                rdPtr_reg <= rdPtr_reg + 1'b1;
            end
            count_reg <= count_reg + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
        end
    end
endmodule

module daq_board_isa_register_decode #(
    parameter int FIFO_WORDS = daq_pkg::FIFO_DEPTH,
    parameter int CONV_WAIT = daq_pkg::CONV_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [daq_pkg::ADDR_W-1:0] ioAddr,
    input wire logic addrEnable,
    input wire logic ioRead_n,
    input wire logic ioWrite_n,
    input wire logic [7:0] dataIn,
    output logic [7:0] dataOut,
    output logic dataOe_n,
    input wire logic [5:0] base_address_switch,
    input wire logic input_wiring_select,
    input wire logic trigger_source_select,
    input wire logic [3:0] irq_level_select,
    input wire logic count_clock_source_select,
    input wire logic dma_ack_channel_select,
    input wire logic dma_request_channel_select,
    input wire logic pacer_gate_event_select,
    input wire logic internal_clock_2m,
    input wire logic external_count_clock_in,
    input wire logic external_conversion_trigger_in,
    output daq_pkg::timer_access_type timerAccess,
    input wire logic [7:0] timerReadData,
    output daq_pkg::timer_wiring_type timerWiring,
    input wire logic timer0Out,
    input wire logic timer1Out,
    input wire logic timer2Out,
    output logic convStart,
    input wire logic [daq_pkg::SAMPLE_W-1:0] adcResultIn,
    output logic [3:0] analogChannel,
    output logic [3:0] gainCode,
    output logic [11:0] dacFirst,
    output logic [11:0] dacSecond,
    input wire logic [15:0] digitalIn,
    output logic [15:0] digitalOut,
    output logic [15:0] irqLines,
    output logic dmaRequest1,
    output logic dmaRequest3,
    input wire logic dmaAck1_n,
    input wire logic dmaAck3_n,
    input wire logic dmaTerminalCount
);
    import daq_pkg::*;

    localparam int WAIT_W = $clog2(CONV_WAIT + 1);

    wire baseMatch = (ioAddr[BASE_HI:BASE_LO] == ~base_address_switch);
    wire selected = baseMatch && !addrEnable;
    wire [OFF_W-1:0] offset = ioAddr[OFF_W-1:0];

    // host strobes, acted on at their trailing edge
    logic readPrev_n_reg;
    logic writePrev_n_reg;
    logic [OFF_W-1:0] lastOffset_reg;
    logic lastSelected_reg;
    logic [7:0] lastData_reg;
    wire writeDone = !writePrev_n_reg && ioWrite_n && lastSelected_reg;
    wire readDone = !readPrev_n_reg && ioRead_n && lastSelected_reg;
    wire writeAt [16];
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_strobe
            assign writeAt[gi] = writeDone && (lastOffset_reg == 4'(gi));
        end
    endgenerate

    // configuration written by the host
    logic [2:0] mode_reg;
    logic [3:0] gain_reg;
    logic [3:0] channel_reg;
    logic [7:0] dac0Low_reg;
    logic [7:0] dac1Low_reg;
    logic [11:0] dac0_reg;
    logic [11:0] dac1_reg;
    logic [15:0] dout_reg;

    // conversion engine
    conv_state_type state_reg;
    conv_state_type state_next;
    logic [WAIT_W-1:0] wait_reg;
    logic pending_reg;
    logic irqStatus_reg;
    logic [1:0] pacerSync_reg;
    logic [1:0] extSync_reg;
    logic [SAMPLE_W-1:0] lastResult_reg;
    logic dmaHigh_reg;
    logic [7:0] dataOut_reg;

    wire fifoInReady;
    wire fifoOutValid;
    wire [SAMPLE_W-1:0] fifoOutData;

    wire softMode = (mode_reg == MODE_SOFT_POLL);
    wire dmaMode = (mode_reg == MODE_PACER_DMA);
    wire irqMode = (mode_reg == MODE_PACER_IRQ);
    wire pacedMode = dmaMode || irqMode;
    wire pacerEdge = pacerSync_reg[0] && !pacerSync_reg[1];
    wire extEdge = extSync_reg[0] && !extSync_reg[1];
    wire internalTrig = (softMode && writeAt[OFF_SOFT_START])
        || (pacedMode && pacerEdge);
    wire externalTrig = pacedMode && extEdge;
    wire trigger = trigger_source_select ? externalTrig : internalTrig;
    // full fifo holds back the trigger, so no sample is overwritten
    wire trigTaken = trigger && (state_reg == CONV_IDLE) && fifoInReady;
    wire convDone = (state_reg == CONV_STORE);

    // dma read of a sample takes two byte cycles, low then high
    // acknowledge on the selected channel
    wire dmaAck = dma_ack_channel_select ? !dmaAck3_n : !dmaAck1_n;
    wire dmaRead = dmaAck && !ioRead_n;
    wire dmaReadDone = dmaAck && !readPrev_n_reg && ioRead_n;
    wire hostPop = readDone && (lastOffset_reg == OFF_ADC_HIGH);
    wire fifoPop = hostPop || (dmaReadDone && dmaHigh_reg);
    wire [SAMPLE_W-1:0] shownResult = fifoOutValid ? fifoOutData
        : lastResult_reg;

    sample_fifo #(
        .WIDTH(SAMPLE_W),
        .DEPTH(FIFO_WORDS)
    ) u_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .inValid(convDone),
        .inReady(fifoInReady),
        .inData(adcResultIn),
        .outValid(fifoOutValid),
        .outReady(fifoPop),
        .outData(fifoOutData)
    );

    // read data selection
    // high byte layout
    wire [7:0] adcHigh = {3'h0, pending_reg, shownResult[11:8]};
    logic [7:0] readValue;
    logic readable;
    always_comb begin
        readValue = 8'h00;
        readable = 1'b0;
        if (offset < OFF_TIMER_CTRL) begin
            readValue = timerReadData;
            readable = 1'b1;
        end else begin
            case (offset)
                OFF_ADC_LOW: begin
                    readValue = shownResult[7:0];
                    readable = 1'b1;
                end
                OFF_ADC_HIGH: begin
                    readValue = adcHigh;
                    readable = 1'b1;
                end
                OFF_DIN_LOW: begin
                    readValue = digitalIn[7:0];
                    readable = 1'b1;
                end
                OFF_DIN_HIGH: begin
                    readValue = digitalIn[15:8];
                    readable = 1'b1;
                end
                default: begin
                    readValue = 8'h00;
                    readable = 1'b0;
                end
            endcase
        end
    end

    wire [7:0] dmaValue = dmaHigh_reg ? {4'h0, shownResult[11:8]}
        : shownResult[7:0];
    // reserved reads leave the bus alone
    assign dataOe_n = !((selected && !ioRead_n && readable) || dmaRead);
    assign dataOut = dataOut_reg;

    assign timerAccess.select = offset[1:0];
    assign timerAccess.read = selected && !ioRead_n
        && (offset < OFF_TIMER_CTRL);
    assign timerAccess.write = selected && !ioWrite_n
        && (offset <= OFF_TIMER_CTRL);
    assign timerAccess.data = dataIn;
    assign timerWiring.clock0 = count_clock_source_select
        ? external_count_clock_in : internal_clock_2m;
    assign timerWiring.clock2 = timer1Out;
    // event gate for the pacer pair
    assign timerWiring.gate12 = pacer_gate_event_select ? timer0Out : 1'b1;

    // differential ignores the top channel bit
    assign analogChannel = input_wiring_select
        ? {1'b0, channel_reg[2:0]} : channel_reg;
    assign gainCode = gain_reg;
    assign dacFirst = dac0_reg;
    assign dacSecond = dac1_reg;
    assign digitalOut = dout_reg;
    assign convStart = trigTaken;
    // one level, only in interrupt transfer
    assign irqLines = (irqStatus_reg && irqMode)
        ? (16'h0001 << irq_level_select) : 16'h0000;
    // request only in dma mode on the chosen channel
    wire dmaWant = dmaMode && fifoOutValid;
    assign dmaRequest1 = dmaWant && !dma_request_channel_select;
    assign dmaRequest3 = dmaWant && dma_request_channel_select;

    // busy for the converter time, then store
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            CONV_IDLE: begin
                if (trigTaken) begin
                    state_next = CONV_BUSY;
                end
            end
            CONV_BUSY: begin
                if (wait_reg == WAIT_W'(CONV_WAIT - 1)) begin
                    state_next = CONV_STORE;
                end
            end
            CONV_STORE: begin
                state_next = CONV_IDLE;
            end
            default: begin
                state_next = CONV_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            readPrev_n_reg <= 1'b1;
            writePrev_n_reg <= 1'b1;
            lastOffset_reg <= '0;
            lastSelected_reg <= 1'b0;
            lastData_reg <= 8'h00;
            dataOut_reg <= 8'h00;
        end else begin
            readPrev_n_reg <= ioRead_n;
            writePrev_n_reg <= ioWrite_n;
            lastOffset_reg <= offset;
            lastSelected_reg <= selected;
            lastData_reg <= dataIn;
            dataOut_reg <= dmaRead ? dmaValue : readValue;
        end
    end

    // control writes at 9, a, b
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_reg <= MODE_OFF;
            gain_reg <= 4'h0;
            channel_reg <= 4'h0;
        end else begin
            if (writeAt[OFF_GAIN]) begin
                gain_reg <= lastData_reg[3:0];
            end
            if (writeAt[OFF_CHANNEL]) begin
                channel_reg <= lastData_reg[3:0];
            end
            if (writeAt[OFF_MODE]) begin
                mode_reg <= lastData_reg[2:0];
            end
        end
    end

    // high byte write updates the whole output
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            dac0Low_reg <= 8'h00;
            dac1Low_reg <= 8'h00;
            dac0_reg <= 12'h000;
            dac1_reg <= 12'h000;
        end else begin
            if (writeAt[OFF_DAC0_LOW]) begin
                dac0Low_reg <= lastData_reg;
            end
            if (writeAt[OFF_DAC1_LOW]) begin
                dac1Low_reg <= lastData_reg;
            end
            if (writeAt[OFF_DAC0_HIGH]) begin
                dac0_reg <= {lastData_reg[3:0], dac0Low_reg};
            end
            if (writeAt[OFF_DAC1_HIGH]) begin
                dac1_reg <= {lastData_reg[3:0], dac1Low_reg};
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            dout_reg <= 16'h0000;
        end else begin
            if (writeAt[OFF_DOUT_LOW]) begin
                dout_reg[7:0] <= lastData_reg;
            end
            if (writeAt[OFF_DOUT_HIGH]) begin
                dout_reg[15:8] <= lastData_reg;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= CONV_IDLE;
            wait_reg <= '0;
            pacerSync_reg <= 2'h0;
            extSync_reg <= 2'h0;
        end else begin
            state_reg <= state_next;
            wait_reg <= (state_reg == CONV_BUSY)
                ? wait_reg + 1'b1 : '0;
            pacerSync_reg <= {pacerSync_reg[0], timer2Out};
            extSync_reg <= {extSync_reg[0], external_conversion_trigger_in};
        end
    end

    // pending until the sample is stored
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pending_reg <= 1'b0;
            lastResult_reg <= '0;
        end else begin
            if (trigTaken) begin
                pending_reg <= 1'b1;
            end else if (convDone) begin
                pending_reg <= 1'b0;
            end
            if (fifoPop && fifoOutValid) begin
                lastResult_reg <= fifoOutData;
            end
        end
    end

    // set wins over a clear in the same cycle
    // per-conversion status, cleared by write at 8
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irqStatus_reg <= 1'b0;
            dmaHigh_reg <= 1'b0;
        end else begin
            if ((convDone && irqMode) || (dmaMode && dmaTerminalCount)) begin
                irqStatus_reg <= 1'b1;
            end else if (writeAt[OFF_IRQ_CLEAR]) begin
                irqStatus_reg <= 1'b0;
            end
            if (dmaReadDone) begin
                dmaHigh_reg <= !dmaHigh_reg;
            end
        end
    end
endmodule

// *** testbench/daq_far_model.sv ***
// timer and converter stand-in on the far side of the decode block
`timescale 1ns/100ps
module daq_far_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire daq_pkg::timer_access_type timerAccess,
    output logic [7:0] timerReadData,
    output logic timer0Out,
    output logic timer1Out,
    output logic timer2Out,
    output logic [daq_pkg::SAMPLE_W-1:0] adcResultIn
);
    import daq_pkg::*;
    logic [7:0] tick_reg;
    // counter data only while read, inverted junk otherwise
    assign timerReadData = {6'h28, timerAccess.select}
        ^ {8{!timerAccess.read}};
    // counter 1 clocks counter 2, whose rise paces conversions
    assign timer1Out = tick_reg[0];
    assign timer2Out = tick_reg[6];
    assign timer0Out = tick_reg[3];
    assign adcResultIn = 12'h5c3;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tick_reg <= 8'h00;
        end else begin
            tick_reg <= tick_reg + 8'h01;
        end
    end
endmodule

// *** testbench/daq_board_isa_register_decode_asserts.sv ***
// port-level checks on the acquisition card decode
`timescale 1ns/100ps
module daq_decode_checker (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [daq_pkg::ADDR_W-1:0] ioAddr,
    input wire logic addrEnable,
    input wire logic ioRead_n,
    input wire logic ioWrite_n,
    input wire logic [7:0] dataIn,
    input wire logic dataOe_n,
    input wire logic [5:0] base_address_switch,
    input wire logic [3:0] irq_level_select,
    input wire logic count_clock_source_select,
    input wire logic dma_request_channel_select,
    input wire logic pacer_gate_event_select,
    input wire logic internal_clock_2m,
    input wire logic external_count_clock_in,
    input wire daq_pkg::timer_access_type timerAccess,
    input wire daq_pkg::timer_wiring_type timerWiring,
    input wire logic timer0Out,
    input wire logic timer1Out,
    input wire logic convStart,
    input wire logic [15:0] irqLines,
    input wire logic dmaRequest1,
    input wire logic dmaRequest3
);
    import daq_pkg::*;
    // switch on means the address bit must be zero
    wire hit = ioAddr[BASE_HI:BASE_LO] == ~base_address_switch;
    wire inWindow = hit && !addrEnable;
    wire [3:0] offset = ioAddr[3:0];
    wire readable = !offset[3] && offset != OFF_TIMER_CTRL;
    wire timerSpot = offset[3:2] == 2'h0;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_read_drive_only: assert property (
        !dataOe_n |-> inWindow && !ioRead_n && readable)
        else $error("bus driven off a readable port");
    a_read_drive_hit: assert property (
        inWindow && !ioRead_n && readable |-> !dataOe_n)
        else $error("readable port not driven");
    a_start_single: assert property (
        convStart |=> !convStart)
        else $error("start pulse too long");
    a_irq_one_level: assert property (
        irqLines != 16'h0000 |-> irqLines == 16'h0001 << irq_level_select)
        else $error("interrupt on wrong line");
    a_dma_one_channel: assert property (
        dmaRequest1 || dmaRequest3 |-> dmaRequest1 != dmaRequest3
        && dmaRequest3 == dma_request_channel_select)
        else $error("dma request on wrong channel");
    a_count_clock_mux: assert property (
        timerWiring.clock0 == (count_clock_source_select ?
        external_count_clock_in : internal_clock_2m))
        else $error("counter 0 clock wrong");
    a_pacer_gate: assert property (
        timerWiring.gate12 == (pacer_gate_event_select ? timer0Out : 1'b1))
        else $error("pacer gate wrong");
    a_pacer_cascade: assert property (
        timerWiring.clock2 == timer1Out)
        else $error("pacer cascade broken");
    a_timer_read: assert property (
        timerAccess.read == (inWindow && !ioRead_n && timerSpot && readable)
        && (!timerAccess.read || timerAccess.select == offset[1:0]))
        else $error("timer read strobe wrong");
    a_timer_write: assert property (
        timerAccess.write == (inWindow && !ioWrite_n && timerSpot)
        && (!timerAccess.write || timerAccess.data == dataIn))
        else $error("timer write strobe wrong");
endmodule
bind daq_board_isa_register_decode daq_decode_checker u_checker (
    .clk, .sys_rst, .ioAddr, .addrEnable, .ioRead_n, .ioWrite_n, .dataIn,
    .dataOe_n, .base_address_switch, .irq_level_select,
    .count_clock_source_select, .dma_request_channel_select,
    .pacer_gate_event_select, .internal_clock_2m, .external_count_clock_in,
    .timerAccess, .timerWiring, .timer0Out, .timer1Out, .convStart,
    .irqLines, .dmaRequest1, .dmaRequest3
);

// *** testbench/daq_board_isa_register_decode_test.sv ***
// self-checking bench for the acquisition card io decode
`timescale 1ns/100ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin \
    err_count++; $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module daq_board_isa_register_decode_test;
    import daq_pkg::*;
    localparam logic [9:0] B = FACTORY_BASE;
    logic clk = 1'b0, sys_rst = 1'b1, clk2m = 1'b0;
    logic [9:0] ioAddr = 10'h000;
    logic addrEnable = 1'b0, ioRead_n = 1'b1, ioWrite_n = 1'b1, trigSel = 1'b0;
    logic [7:0] dataIn = 8'h00, dataOut, timerReadData, rdData;
    logic dataOe_n, rdOe_n, dmaRequest1, dmaRequest3, dmaTc = 1'b0;
    logic [5:0] baseSwitch = FACTORY_SWITCH;
    logic wiringSel = 1'b0, clockSel = 1'b0, dmaSel = 1'b0, gateSel = 1'b0;
    logic [3:0] irqSel = 4'h0, analogChannel, gainCode;
    logic timer0Out, timer1Out, timer2Out, convStart;
    timer_access_type timerAccess;
    timer_wiring_type timerWiring;
    logic [11:0] adcResultIn, dacFirst, dacSecond;
    logic [15:0] digitalIn = 16'h5aa5, digitalOut, irqLines;
    int err_count = 0, check_count = 0, convCount = 0, n0;
    initial forever #12.5 clk = ~clk;
    initial forever #250 clk2m = ~clk2m;
    always @(posedge clk) if (convStart === 1'b1) convCount++;
    daq_board_isa_register_decode #(.FIFO_WORDS(16), .CONV_WAIT(16)) DUT (
        .clk, .sys_rst, .ioAddr, .addrEnable, .ioRead_n, .ioWrite_n,
        .dataIn, .dataOut, .dataOe_n, .base_address_switch(baseSwitch),
        .input_wiring_select(wiringSel), .trigger_source_select(trigSel),
        .irq_level_select(irqSel), .count_clock_source_select(clockSel),
        .dma_ack_channel_select(1'b0), .dma_request_channel_select(dmaSel),
        .pacer_gate_event_select(gateSel), .internal_clock_2m(clk2m),
        .external_count_clock_in(~clk2m),
        .external_conversion_trigger_in(timer0Out), .timerAccess,
        .timerReadData, .timerWiring, .timer0Out, .timer1Out, .timer2Out,
        .convStart, .adcResultIn, .analogChannel, .gainCode, .dacFirst,
        .dacSecond, .digitalIn, .digitalOut, .irqLines, .dmaRequest1,
        .dmaRequest3, .dmaAck1_n(1'b1), .dmaAck3_n(1'b1),
        .dmaTerminalCount(dmaTc)
    );
    daq_far_model far (.clk, .sys_rst, .timerAccess, .timerReadData,
        .timer0Out, .timer1Out, .timer2Out, .adcResultIn);
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // isa write cycle, acted on at the trailing edge
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(negedge clk);
        ioAddr = a;
        dataIn = d;
        ioWrite_n = 1'b0;
        repeat (2) @(negedge clk);
        ioWrite_n = 1'b1;
        repeat (2) @(negedge clk);
    endtask
    task automatic rd(input logic [9:0] a);
        @(negedge clk);
        ioAddr = a;
        ioRead_n = 1'b0;
        repeat (2) @(negedge clk);
        rdData = dataOut;
        rdOe_n = dataOe_n;
        ioRead_n = 1'b1;
        @(negedge clk);
    endtask
    task automatic wait_irq;
        for (int i = 0; i < 3000; i++) begin
            @(negedge clk);
            if ((|irqLines) === 1'b1) return;
        end
        `CHK("irq wait", 1'b1, 1'b0)
        test_done();
    endtask
    initial begin
        repeat (6) @(negedge clk);
        sys_rst = 1'b0;
        wr(B + 10'h00d, 8'h3c);
        wr(B + 10'h00e, 8'hc3);
        `CHK("dout", 16'hc33c, digitalOut)
        wr(B + 10'h01d, 8'h00);
        addrEnable = 1'b1;
        wr(B + 10'h00d, 8'h00);
        addrEnable = 1'b0;
        wr(B + 10'h00f, 8'h00);
        `CHK("dout kept", 16'hc33c, digitalOut)
        baseSwitch = 6'h00;
        wr(10'h3fd, 8'h77);
        `CHK("dout moved", 16'hc377, digitalOut)
        baseSwitch = FACTORY_SWITCH;
        $display("window test done");
        wr(B + 10'h003, 8'h36);
        for (int i = 0; i < 3; i++) begin
            rd(B + 10'(i));
            `CHK("timer", {6'h28, 2'(i)}, rdData)
        end
        rd(B + 10'h006);
        `CHK("din low", 8'ha5, rdData)
        rd(B + 10'h007);
        `CHK("din high", 8'h5a, rdData)
        for (int i = 3; i < 16; i += (i == 3) ? 5 : 1) begin
            rd(B + 10'(i));
            `CHK("idle bus", 1'b1, rdOe_n)
        end
        rd(B + 10'h016);
        `CHK("other window", 1'b1, rdOe_n)
        $display("read test done");
        wr(B + 10'h004, 8'h12);
        `CHK("dac hold", 12'h000, dacFirst)
        wr(B + 10'h005, 8'hf7);
        `CHK("dac first", 12'h712, dacFirst)
        wr(B + 10'h005, 8'h02);
        `CHK("dac high only", 12'h212, dacFirst)
        wr(B + 10'h006, 8'h34);
        wr(B + 10'h007, 8'h09);
        `CHK("dac second", 12'h934, dacSecond)
        wr(B + 10'h009, 8'hfb);
        `CHK("gain", 4'hb, gainCode)
        wr(B + 10'h00a, 8'h0f);
        `CHK("chan single", 4'hf, analogChannel)
        wiringSel = 1'b1;
        wr(B + 10'h00a, 8'h0f);
        `CHK("chan diff", 4'h7, analogChannel)
        gateSel = 1'b1;
        clockSel = 1'b1;
        repeat (40) @(negedge clk);
        $display("control test done");
        wr(B + 10'h00b, 8'h01);
        n0 = convCount;
        wr(B + 10'h00c, 8'h00);
        wr(B + 10'h00c, 8'h00);
        rd(B + 10'h005);
        `CHK("pending", 8'h10, rdData)
        repeat (20) @(negedge clk);
        `CHK("one start", n0 + 1, convCount)
        rd(B + 10'h004);
        `CHK("adc low", 8'hc3, rdData)
        rd(B + 10'h005);
        `CHK("adc high", 8'h05, rdData)
        trigSel = 1'b1;
        wr(B + 10'h00c, 8'h00);
        `CHK("ext select", n0 + 1, convCount)
        $display("poll test done");
        dmaSel = 1'b1;
        dmaTc = 1'b1;
        n0 = convCount;
        wr(B + 10'h00b, 8'h02);
        repeat (2800) @(negedge clk);
        `CHK("fifo full", n0 + 16, convCount)
        `CHK("dma ch3", 1'b1, dmaRequest3)
        dmaSel = 1'b0;
        @(negedge clk);
        `CHK("dma ch1", 1'b1, dmaRequest1)
        wr(B + 10'h00b, 8'h00);
        `CHK("dma off", 1'b0, dmaRequest1)
        for (int i = 0; i < 16; i++) begin
            rd(B + 10'h004);
            `CHK("drain low", 8'hc3, rdData)
            rd(B + 10'h005);
            `CHK("drain high", 8'h05, rdData)
        end
        $display("buffer test done");
        irqSel = 4'h5;
        wr(B + 10'h00b, 8'h06);
        `CHK("tc irq", 16'h0020, irqLines)
        wr(B + 10'h008, 8'h5a);
        `CHK("irq clear", 16'h0000, irqLines)
        wait_irq();
        `CHK("irq", 16'h0020, irqLines)
        wr(B + 10'h008, 8'h5a);
        wait_irq();
        `CHK("irq again", 16'h0020, irqLines)
        wr(B + 10'h00b, 8'h00);
        `CHK("irq mode off", 16'h0000, irqLines)
        $display("interrupt test done");
        test_done();
    end
endmodule
